// ---- common/ebc_map.svh ----
// field positions, segment widths and the reset value of the bus controller
// Notes on behaviour
// - single-chip or four external modes: 8/16-bit data, muxed or demuxed, 16-24 bit addr
// - demuxed: address on dedicated port, data on shared port, low byte for 8-bit
// - muxed: shared port carries address first, then data, each access
// - cycle time, tri-state time, latch-enable length and read/write delay programmable
// - four windows, each an address-select and bus-config pair with own timing
// - window 4 overrides 3, window 2 overrides 1 where they overlap
// - addresses outside all windows use the default bus configuration
// - five chip-selects: one per window plus one for the default region
// - unlatched chip-select bit bypasses filter; chip-selects decode straight from address
// - ready input from slow device stretches the access
// - hold-enable set: controller runs bus-request, hold-acknowledge and hold pins
// - master after reset, acknowledge output; direction bit 1 selects slave, acknowledge input
// - 1M, 256K, 64K space: segment port drives four, two or no lines
// - 16M space: segment port drives all eight upper lines
// - CAN lines on segment port win, segment limited to six or four bits
// - on-chip modules active only with enable bit; disabled ones take no space or pins
`ifndef EBC_MAP_SVH
`define EBC_MAP_SVH
// bus config fields
`define EBC_CFG_MCTC_LSB   0
`define EBC_CFG_MTTC_BIT   4
`define EBC_CFG_RWDC_BIT   5
`define EBC_CFG_ALECTL_BIT 6
`define EBC_CFG_MODE_LSB   7
`define EBC_CFG_RDYEN_BIT  9
`define EBC_CFG_BUSACT_BIT 10
// address select fields: range size in low nibble, start in upper bits
`define EBC_SEL_RGSZ_LSB   0
`define EBC_SEL_RGSAD_LSB  4
// system config bits
`define EBC_SYS_ONCHIP_MODULE_ENABLE_BIT   2
`define EBC_SYS_UNLATCHED_CS_ENABLE_BIT  6
// segment widths
`define EBC_SEG_FULL       4'h8
`define EBC_SEG_1M         4'h4
`define EBC_SEG_256K       4'h2
`define EBC_SEG_64K        4'h0
`define EBC_SEG_CAN1       4'h6
`define EBC_SEG_CAN2       4'h4
`define EBC_RESET_CFG      16'h0000
`endif

// ---- common/ebc_pkg.sv ----
// types of the bus controller
package ebc_pkg;
  typedef enum logic [1:0] {EBC_DMX8, EBC_MUX8, EBC_DMX16, EBC_MUX16} ebc_mode_t;
  typedef enum logic [1:0] {EBC_SP64K, EBC_SP256K, EBC_SP1M, EBC_SP16M} ebc_space_t;
  typedef enum logic [2:0] {
    EBC_IDLE, EBC_ADDR, EBC_DELAY, EBC_DATA, EBC_TRI, EBC_HELD
  } ebc_state_t;
endpackage : ebc_pkg

// ---- rtl/ebc_window.sv ----
// one address window compare
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.svh"
module ebc_window #(
  parameter int AW = 24
) (
  // window setup
  input  wire logic [15:0] sel,
  input  wire logic        act,
  // address
  input  wire logic [AW-1:0] addr,
  output logic             hit
);
  // range size n gives a 4K << n window aligned to its size
  logic [3:0]  rgsz;
  logic [11:0] start;
  logic [23:0] mask;
  always_comb begin
    rgsz  = sel[`EBC_SEL_RGSZ_LSB +: 4];
    start = sel[`EBC_SEL_RGSAD_LSB +: 12];
    mask  = 24'hFFFFFF << (12 + rgsz);
    hit   = act && (((24'(addr) ^ {start, 12'h000}) & mask) == 24'h000000);
  end
endmodule : ebc_window
`default_nettype wire

// ---- rtl/ebc_arbiter.sv ----
// hold / acknowledge arbitration
`timescale 1ns/1ps
`default_nettype none
module ebc_arbiter (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic hold_enable,
  input  wire logic slave_mode,
  input  wire logic cycle_idle,
  // pins
  input  wire logic hold_n,
  input  wire logic ack_in_n,
  output logic      ack_out_n,
  output logic      ack_oe,
  output logic      req_n,
  output logic      req_oe,
  // to controller
  output logic      bus_float,
  output logic      grant_pending
);
  typedef struct packed {
    logic granted;
    logic req;
  } ebc_arb_t;
  ebc_arb_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (!hold_enable) begin
      s_nxt = '0;
    end else if (!slave_mode) begin
      // grant only once the cycle has ended
      if (!hold_n && cycle_idle) begin
        s_nxt.granted = 1'b1;
      end else if (hold_n) begin
        s_nxt.granted = 1'b0;
      end
      s_nxt.req = 1'b0;
    end else begin
      // slave: ask for bus while not owning it; float unless acknowledged
      s_nxt.granted = ack_in_n;
      s_nxt.req     = ack_in_n;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // gated by enable: the grant bit lags one cycle when arbitration is switched off
  assign ack_out_n     = ~(s_r.granted && hold_enable && !slave_mode);
  assign ack_oe        = hold_enable && !slave_mode;
  assign req_n         = ~s_r.req;
  assign req_oe        = hold_enable;
  assign bus_float     = s_r.granted;
  assign grant_pending = hold_enable && !slave_mode && !hold_n;
endmodule : ebc_arbiter
`default_nettype wire

// ---- rtl/ebc_ctrl.sv ----
// external bus controller top
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.svh"
module ebc_ctrl #(
  parameter int AW = 24,
  parameter int NW = 4
) (
  // clock and reset
  input  wire logic          MCLK,
  input  wire logic          RST,
  // configuration
  input  wire logic          EXT_BUS_EN,
  input  wire logic [15:0]   DEFAULT_BUS_CONFIG,
  input  wire logic [15:0]   WINDOW_BUS_CONFIG [NW],
  input  wire logic [15:0]   WINDOW_ADDR_SELECT [NW],
  input  wire logic [15:0]   SYSTEM_CONFIG_REG,
  input  wire logic [1:0]    ADDR_SPACE,
  input  wire logic [1:0]    CAN_ON_SEG,
  input  wire logic [1:0]    ONCHIP_MODULE_SELECT,
  input  wire logic          HOLD_ENABLE,
  input  wire logic          PORT6_PIN7_DIRECTION,
  // core request
  input  wire logic          REQ,
  input  wire logic          WR,
  input  wire logic [AW-1:0] ADDR,
  input  wire logic [15:0]   WDATA,
  output logic               ACK,
  output logic [15:0]        RDATA,
  output logic               BUSY,
  // on-chip module enables
  output logic [1:0]         ONCHIP_MODULE_ACTIVE,
  // shared and dedicated ports
  input  wire logic [15:0]   SHARED_IN,
  output logic [15:0]        SHARED_OUT,
  output logic [15:0]        SHARED_OE,
  output logic [15:0]        DEDICATED_ADDRESS_PORT,
  output logic               DEDICATED_OE,
  output logic [7:0]         SEG_ADDR,
  output logic [7:0]         SEG_OE,
  // strobes
  output logic               ALE,
  output logic               RD_N,
  output logic               WR_N,
  output logic [4:0]         CS_N,
  input  wire logic          READY_N,
  // arbitration
  input  wire logic          HOLD_N,
  input  wire logic          HOLD_ACK_IN_N,
  output logic               HOLD_ACKNOWLEDGE_N,
  output logic               HOLD_ACK_OE,
  output logic               BUS_REQUEST_N,
  output logic               BUS_REQUEST_OE
);
  typedef struct packed {
    ebc_pkg::ebc_state_t st;
    logic [3:0]          cnt;
    logic [15:0]         cfg;
    logic [AW-1:0]       adr;
    logic [15:0]         wd;
    logic                wr;
    logic [15:0]         rd;
    logic                ack;
    logic [4:0]          cs_n;
    logic                ale;
    logic                rd_n;
    logic                wr_n;
  } ebc_state_r_t;
  ebc_state_r_t s_r, s_nxt;

  logic [NW-1:0] hit;
  logic [4:0]    cs_dec;
  logic [15:0]   sel_cfg;
  logic          bus_float;
  logic          grant_pending;
  logic          cycle_idle;

  genvar gi;
  generate
    for (gi = 0; gi < NW; gi++) begin : g_win
      ebc_window #(.AW(AW)) u_win (
        .sel  (WINDOW_ADDR_SELECT[gi]),
        .act  (WINDOW_BUS_CONFIG[gi][`EBC_CFG_BUSACT_BIT]),
        .addr (ADDR),
        .hit  (hit[gi])
      );
    end
  endgenerate

  // index 3 is window 4; higher pair outranks lower
  always_comb begin
    cs_dec  = 5'h1F;
    sel_cfg = DEFAULT_BUS_CONFIG;
    if (hit[3]) begin
      sel_cfg = WINDOW_BUS_CONFIG[3];
      cs_dec  = 5'h1F & ~5'h10;
    end else if (hit[2]) begin
      sel_cfg = WINDOW_BUS_CONFIG[2];
      cs_dec  = 5'h1F & ~5'h08;
    end else if (hit[1]) begin
      sel_cfg = WINDOW_BUS_CONFIG[1];
      cs_dec  = 5'h1F & ~5'h04;
    end else if (hit[0]) begin
      sel_cfg = WINDOW_BUS_CONFIG[0];
      cs_dec  = 5'h1F & ~5'h02;
    end else begin
      cs_dec  = 5'h1E;
    end
  end

  ebc_arbiter u_arb (
    .clk           (MCLK),
    .rst           (RST),
    .hold_enable   (HOLD_ENABLE),
    .slave_mode    (PORT6_PIN7_DIRECTION),
    .cycle_idle    (cycle_idle),
    .hold_n        (HOLD_N),
    .ack_in_n      (HOLD_ACK_IN_N),
    .ack_out_n     (HOLD_ACKNOWLEDGE_N),
    .ack_oe        (HOLD_ACK_OE),
    .req_n         (BUS_REQUEST_N),
    .req_oe        (BUS_REQUEST_OE),
    .bus_float     (bus_float),
    .grant_pending (grant_pending)
  );

  function automatic logic is_mux(input logic [15:0] c);
    is_mux = c[`EBC_CFG_MODE_LSB];
  endfunction : is_mux

  function automatic logic is_16(input logic [15:0] c);
    is_16 = c[`EBC_CFG_MODE_LSB + 1];
  endfunction : is_16

  assign cycle_idle = (s_r.st == ebc_pkg::EBC_IDLE);

  always_comb begin
    s_nxt     = s_r;
    s_nxt.ack = 1'b0;
    case (s_r.st)
      ebc_pkg::EBC_IDLE: begin
        s_nxt.cs_n = 5'h1F;
        if (bus_float) begin
          s_nxt.st = ebc_pkg::EBC_HELD;
        end else if (REQ && EXT_BUS_EN && !grant_pending) begin
          s_nxt.st   = ebc_pkg::EBC_ADDR;
          s_nxt.cfg  = sel_cfg;
          s_nxt.adr  = ADDR;
          s_nxt.wd   = WDATA;
          s_nxt.wr   = WR;
          s_nxt.ale  = 1'b1;
          s_nxt.cs_n = cs_dec;
          s_nxt.cnt  = sel_cfg[`EBC_CFG_ALECTL_BIT] ? 4'h1 : 4'h0;
        end
      end
      ebc_pkg::EBC_ADDR: begin
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else begin
          s_nxt.ale = 1'b0;
          s_nxt.st  = ebc_pkg::EBC_DELAY;
          s_nxt.cnt = s_r.cfg[`EBC_CFG_RWDC_BIT] ? 4'h0 : 4'h1;
        end
      end
      ebc_pkg::EBC_DELAY: begin
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else begin
          s_nxt.st   = ebc_pkg::EBC_DATA;
          s_nxt.rd_n = s_r.wr;
          s_nxt.wr_n = !s_r.wr;
          s_nxt.cnt  = s_r.cfg[`EBC_CFG_MCTC_LSB +: 4];
        end
      end
      ebc_pkg::EBC_DATA: begin
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else if (!s_r.cfg[`EBC_CFG_RDYEN_BIT] || !READY_N) begin
          s_nxt.rd   = is_16(s_r.cfg) ? SHARED_IN : {8'h00, SHARED_IN[7:0]};
          s_nxt.ack  = 1'b1;
          s_nxt.rd_n = 1'b1;
          s_nxt.wr_n = 1'b1;
          s_nxt.cs_n = 5'h1F;
          s_nxt.st   = ebc_pkg::EBC_TRI;
          s_nxt.cnt  = s_r.cfg[`EBC_CFG_MTTC_BIT] ? 4'h0 : 4'h1;
        end
      end
      ebc_pkg::EBC_TRI: begin
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else begin
          s_nxt.st = ebc_pkg::EBC_IDLE;
        end
      end
      ebc_pkg::EBC_HELD: begin
        if (!bus_float) begin
          s_nxt.st = ebc_pkg::EBC_IDLE;
        end
      end
      default: begin
        s_nxt.st = ebc_pkg::EBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      s_r      <= '0;
      s_r.st   <= ebc_pkg::EBC_IDLE;
      s_r.cs_n <= 5'h1F;
      s_r.rd_n <= 1'b1;
      s_r.wr_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  logic unlatched;
  logic drive;
  logic addr_phase;
  logic [3:0] seg_w;
  assign unlatched  = SYSTEM_CONFIG_REG[`EBC_SYS_UNLATCHED_CS_ENABLE_BIT];
  assign drive      = EXT_BUS_EN && !bus_float;
  assign addr_phase = (s_r.st == ebc_pkg::EBC_ADDR) || (s_r.st == ebc_pkg::EBC_DELAY);

  always_comb begin
    SHARED_OUT = 16'h0000;
    SHARED_OE  = 16'h0000;
    if (drive && !cycle_idle && s_r.st != ebc_pkg::EBC_TRI) begin
      if (is_mux(s_r.cfg) && addr_phase) begin
        SHARED_OUT = s_r.adr[15:0];
        SHARED_OE  = 16'hFFFF;
      end else if (s_r.wr && s_r.st == ebc_pkg::EBC_DATA) begin
        SHARED_OUT = s_r.wd;
        SHARED_OE  = is_16(s_r.cfg) ? 16'hFFFF : 16'h00FF;
      end
    end
  end

  always_comb begin
    case (ebc_pkg::ebc_space_t'(ADDR_SPACE))
      ebc_pkg::EBC_SP16M:  seg_w = `EBC_SEG_FULL;
      ebc_pkg::EBC_SP1M:   seg_w = `EBC_SEG_1M;
      ebc_pkg::EBC_SP256K: seg_w = `EBC_SEG_256K;
      default:             seg_w = `EBC_SEG_64K;
    endcase
    // CAN lines take the top pins first
    if (CAN_ON_SEG[1] && seg_w > `EBC_SEG_CAN2) begin
      seg_w = `EBC_SEG_CAN2;
    end else if (CAN_ON_SEG[0] && seg_w > `EBC_SEG_CAN1) begin
      seg_w = `EBC_SEG_CAN1;
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      SEG_OE[i] = drive && (i < 32'(seg_w));
    end
    SEG_ADDR = s_r.adr[23:16] & SEG_OE;
  end

  assign DEDICATED_ADDRESS_PORT = is_mux(s_r.cfg) ? 16'h0000 : s_r.adr[15:0];
  assign DEDICATED_OE           = drive && !is_mux(s_r.cfg);
  assign ALE    = s_r.ale;
  assign RD_N   = s_r.rd_n;
  assign WR_N   = s_r.wr_n;
  // unlatched: decode live address, no filter on the registered select
  assign CS_N   = !drive ? 5'h1F : (unlatched ? cs_dec : s_r.cs_n);
  assign ACK    = s_r.ack;
  assign RDATA  = s_r.rd;
  assign BUSY   = !cycle_idle;
  assign ONCHIP_MODULE_ACTIVE = SYSTEM_CONFIG_REG[`EBC_SYS_ONCHIP_MODULE_ENABLE_BIT] ?
                                ONCHIP_MODULE_SELECT : 2'b00;

  a_ack_one_cycle: assert property (@(posedge MCLK) disable iff (RST)
    ACK |=> !ACK) else $error("ack held two cycles");
  a_ready_stall: assert property (@(posedge MCLK) disable iff (RST)
    (s_r.st == ebc_pkg::EBC_DATA && s_r.cnt == 4'h0 && s_r.cfg[9] && READY_N)
    |=> !ACK) else $error("ack without ready");
  a_hold_float: assert property (@(posedge MCLK) disable iff (RST)
    !HOLD_ACKNOWLEDGE_N |-> (SHARED_OE == 16'h0000 && !DEDICATED_OE))
    else $error("bus driven while held");
  a_master_ack_out: assert property (@(posedge MCLK) disable iff (RST)
    (HOLD_ENABLE && !PORT6_PIN7_DIRECTION) |-> HOLD_ACK_OE)
    else $error("ack pin not driven in master");
  a_slave_ack_in: assert property (@(posedge MCLK) disable iff (RST)
    PORT6_PIN7_DIRECTION |-> !HOLD_ACK_OE) else $error("ack driven in slave");
  a_module_gate: assert property (@(posedge MCLK) disable iff (RST)
    !SYSTEM_CONFIG_REG[2] |-> ONCHIP_MODULE_ACTIVE == 2'b00)
    else $error("module active while disabled");
  a_seg_full: assert property (@(posedge MCLK) disable iff (RST)
    (ADDR_SPACE == 2'b11 && CAN_ON_SEG == 2'b00 && drive) |-> SEG_OE == 8'hFF)
    else $error("segment not full width");
  a_cs_latched_idle: assert property (@(posedge MCLK) disable iff (RST)
    (cycle_idle && !unlatched) |-> CS_N == 5'h1F)
    else $error("latched select active while idle");
  a_cs_one_hot: assert property (@(posedge MCLK) disable iff (RST)
    $countones(~CS_N) <= 1) else $error("two chip selects active");
  a_ale_start: assert property (@(posedge MCLK) disable iff (RST)
    (s_r.st == ebc_pkg::EBC_IDLE && $past(s_r.st) == ebc_pkg::EBC_TRI) |-> !ALE)
    else $error("latch enable outside address phase");
endmodule : ebc_ctrl
`default_nettype wire

// ---- verification/ebc_mem_model.sv ----
// external memory with a ready line, standing on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module ebc_mem_model (
  // clock
  input  wire logic        clk,
  // bench control
  input  wire logic        mux,
  input  wire logic [3:0]  slow_n,
  // bus from controller
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] sh_out,
  input  wire logic [15:0] ded,
  // answers
  output logic [15:0]      sh_in,
  output logic             rdy_n
);
  logic [15:0] mem [256];
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  cnt  = 4'h0;
  logic [15:0] last = 16'h0000;

  always @(posedge clk) begin
    if (ale) adr <= mux ? sh_out[7:0] : ded[7:0];
    if (!wr_n) mem[adr] <= sh_out;
    if (!rd_n) last <= mem[adr];
    cnt <= (!rd_n || !wr_n) ? cnt + 4'h1 : 4'h0;
  end

  // released data lines show the inverse, so stale data cannot pass
  assign sh_in = !rd_n ? mem[adr] : ~last;
  assign rdy_n = !((!rd_n || !wr_n) && cnt >= slow_n);
endmodule : ebc_mem_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench of the external bus controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        mclk = 1'b0, rst = 1'b1, ext_en = 1'b1, req = 1'b0, wr = 1'b0;
  logic        hold_en = 1'b0, dir = 1'b0, hold_n = 1'b1, ack_in_n = 1'b1, mux_m = 1'b0;
  logic [15:0] def_cfg = 16'h0500, sys_cfg = 16'h0000, wdata = 16'h0000;
  logic [15:0] win_cfg [4] = '{default: 16'h0000};
  logic [15:0] win_sel [4] = '{default: 16'h0000};
  logic [1:0]  aspace = 2'h3, can_seg = 2'h0, mod_sel = 2'h0;
  logic [23:0] addr = 24'h000000;
  logic [3:0]  slow = 4'h0;
  logic        ack, busy, ale, rd_n, wr_n, ded_oe, rdy_n, hak_n, hak_oe, brq_n, brq_oe;
  logic [15:0] rdata, sh_in, sh_out, sh_oe, ded, rdat, adr_v;
  logic [7:0]  seg, seg_oe, seg_v;
  logic [4:0]  cs_n, cs_v;
  logic [1:0]  mod_act;
  int          err_count = 0, n_tests = 0, tmo = 0, cyc;

  ebc_ctrl u_dut (
    .MCLK(mclk), .RST(rst), .EXT_BUS_EN(ext_en), .DEFAULT_BUS_CONFIG(def_cfg),
    .WINDOW_BUS_CONFIG(win_cfg), .WINDOW_ADDR_SELECT(win_sel),
    .SYSTEM_CONFIG_REG(sys_cfg), .ADDR_SPACE(aspace), .CAN_ON_SEG(can_seg),
    .ONCHIP_MODULE_SELECT(mod_sel), .HOLD_ENABLE(hold_en), .PORT6_PIN7_DIRECTION(dir),
    .REQ(req), .WR(wr), .ADDR(addr), .WDATA(wdata), .ACK(ack), .RDATA(rdata),
    .BUSY(busy), .ONCHIP_MODULE_ACTIVE(mod_act), .SHARED_IN(sh_in),
    .SHARED_OUT(sh_out), .SHARED_OE(sh_oe), .DEDICATED_ADDRESS_PORT(ded),
    .DEDICATED_OE(ded_oe), .SEG_ADDR(seg), .SEG_OE(seg_oe), .ALE(ale), .RD_N(rd_n),
    .WR_N(wr_n), .CS_N(cs_n), .READY_N(rdy_n), .HOLD_N(hold_n),
    .HOLD_ACK_IN_N(ack_in_n), .HOLD_ACKNOWLEDGE_N(hak_n), .HOLD_ACK_OE(hak_oe),
    .BUS_REQUEST_N(brq_n), .BUS_REQUEST_OE(brq_oe)
  );

  ebc_mem_model u_mem (
    .clk(mclk), .mux(mux_m), .slow_n(slow), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .sh_out(sh_out), .ded(ded), .sh_in(sh_in), .rdy_n(rdy_n)
  );

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  always @(posedge mclk) begin
    tmo++;
    if (tmo == 5000) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  function automatic logic [15:0] cfg(input logic [1:0] m, input logic [3:0] w,
                                      input logic r);
    return 16'h0400 | {6'h00, r, m, 3'h0, w};
  endfunction : cfg

  // request held until the acknowledge edge; address phase captured at ALE
  task automatic access(input logic w, input logic [23:0] a, input logic [15:0] d);
    cs_v = 'x;
    seg_v = 'x;
    adr_v = 'x;
    cyc = 0;
    @(posedge mclk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge mclk);
      cyc++;
      if (ale === 1'b1) begin
        cs_v = cs_n;
        seg_v = seg_oe;
        adr_v = mux_m ? sh_out : ded;
      end
    end while (ack !== 1'b1 && cyc < 100);
    rdat = rdata;
    chk("ack", ack, 1'b1);
    req <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : access

  task automatic t_reset();
    @(posedge mclk);
    chk("idle strobes", {ale, rd_n, wr_n, cs_n, ack, busy},
        {1'b0, 1'b1, 1'b1, 5'h1F, 1'b0, 1'b0});
  endtask : t_reset

  task automatic t_modes();
    logic [15:0] d;
    for (int m = 0; m < 4; m++) begin
      d = 16'hA5C3 ^ 16'(m);
      def_cfg <= cfg(2'(m), 4'h0, 1'b0);
      mux_m = m[0];
      access(1'b1, 24'h300010 + 24'(m), d);
      chk("default cs", cs_v, 5'h1E);
      chk("addr phase", adr_v, 16'h0010 + 16'(m));
      access(1'b0, 24'h300010 + 24'(m), 16'h0000);
      chk("read data", rdat, m[1] ? d : {8'h00, d[7:0]});
    end
    mux_m = 1'b0;
    def_cfg <= cfg(ebc_pkg::EBC_DMX16, 4'h0, 1'b0);
  endtask : t_modes

  task automatic t_windows();
    logic [23:0] a [5] = '{24'h010100, 24'h018000, 24'h020100, 24'h028000, 24'h300000};
    logic [4:0]  e [5] = '{5'h1B, 5'h1D, 5'h0F, 5'h17, 5'h1E};
    win_sel <= '{16'h0104, 16'h0100, 16'h0204, 16'h0200};
    win_cfg <= '{default: cfg(ebc_pkg::EBC_DMX16, 4'h0, 1'b0)};
    for (int i = 0; i < 5; i++) begin
      access(1'b1, a[i], 16'h1234);
      chk("window cs", cs_v, e[i]);
    end
    // window 4 alone gets three wait states: its own timing must win the overlap
    win_cfg[3] <= cfg(ebc_pkg::EBC_DMX16, 4'h3, 1'b0);
    access(1'b1, 24'h020100, 16'h1234);
    chk("window timing", cyc, 9);
    chk("window4 cs", cs_v, 5'h0F);
  endtask : t_windows

  task automatic t_timing();
    int c0, c1;
    access(1'b1, 24'h300020, 16'h0001);
    c0 = cyc;
    def_cfg <= cfg(ebc_pkg::EBC_DMX16, 4'h5, 1'b0);
    access(1'b1, 24'h300020, 16'h0002);
    chk("wait count", cyc - c0, 5);
    def_cfg <= cfg(ebc_pkg::EBC_DMX16, 4'h0, 1'b1);
    access(1'b0, 24'h300020, 16'h0000);
    c1 = cyc;
    slow = 4'h4;
    access(1'b0, 24'h300020, 16'h0000);
    chk("ready stretch", cyc - c1, 4);
    chk("slow read", rdat, 16'h0002);
    slow = 4'h0;
    def_cfg <= cfg(ebc_pkg::EBC_DMX16, 4'h0, 1'b0);
  endtask : t_timing

  task automatic t_seg();
    logic [7:0] e [4] = '{8'h00, 8'h03, 8'h0F, 8'hFF};
    for (int s = 0; s < 4; s++) begin
      aspace <= 2'(s);
      access(1'b0, 24'h5A0020, 16'h0000);
      chk("segment lines", seg_v, e[s]);
      chk("segment addr", seg, 8'h5A & e[s]);
    end
    can_seg <= 2'h1;
    access(1'b0, 24'h5A0020, 16'h0000);
    chk("can six", seg_v, 8'h3F);
    chk("can six addr", seg, 8'h1A);
    can_seg <= 2'h2;
    access(1'b0, 24'h5A0020, 16'h0000);
    chk("can four", seg_v, 8'h0F);
    can_seg <= 2'h0;
  endtask : t_seg

  task automatic t_misc();
    @(posedge mclk);
    sys_cfg <= 16'h0040;
    addr <= 24'h018000;
    mod_sel <= 2'h3;
    repeat (2) @(posedge mclk);
    chk("unlatched cs", cs_n, 5'h1D);
    chk("modules off", mod_act, 2'h0);
    addr <= 24'h300000;
    sys_cfg <= 16'h0044;
    repeat (2) @(posedge mclk);
    chk("unlatched default", cs_n, 5'h1E);
    chk("modules on", mod_act, 2'h3);
    sys_cfg <= 16'h0000;
    ext_en <= 1'b0;
    req <= 1'b1;
    cyc = 0;
    repeat (30) begin
      @(posedge mclk);
      if (ack === 1'b1) cyc++;
    end
    chk("single chip", {cyc[3:0], sh_oe}, 20'h00000);
    req <= 1'b0;
    ext_en <= 1'b1;
  endtask : t_misc

  task automatic t_hold();
    @(posedge mclk);
    hold_en <= 1'b1;
    // hold raised two cycles into a write: that write must still complete
    fork
      access(1'b1, 24'h300030, 16'h0055);
      begin
        repeat (3) @(posedge mclk);
        hold_n <= 1'b0;
      end
    join
    cyc = 0;
    do begin
      @(posedge mclk);
      cyc++;
    end while (hak_n !== 1'b0 && cyc < 20);
    chk("ack given", {hak_n, hak_oe}, 2'b01);
    chk("bus floated", {sh_oe, ded_oe}, 17'h00000);
    hold_n <= 1'b1;
    cyc = 0;
    do begin
      @(posedge mclk);
      cyc++;
    end while (hak_n !== 1'b1 && cyc < 20);
    chk("ack released", hak_n, 1'b1);
    dir <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("slave ack input", hak_oe, 1'b0);
    chk("slave request", {brq_oe, brq_n}, 2'b10);
    dir <= 1'b0;
    hold_en <= 1'b0;
  endtask : t_hold

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_modes();
    t_windows();
    t_timing();
    t_seg();
    t_misc();
    t_hold();
    close_out();
  end
endmodule : tb
`default_nettype wire
